// *** line_unit_irq.sv ***
// Purpose: line unit interrupt enables and pending events
// Assumes: single-rail mode set by software; pins synchronised here
// Notes:   pending bits clear by writing one at the interrupt status address
`include "line_unit_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module line_unit_irq #(
  parameter int PTR_W = 5  // jitter fifo pointer width
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic [15:0]               host_addr,   // host port address
  input  wire logic                      host_wr,     // write strobe
  input  wire logic                      host_rd,     // read strobe
  input  wire line_unit_pkg::byte_t      host_wdata,  // write data
  output line_unit_pkg::byte_t           host_rdata,  // read data, registered
  input  wire logic                      line_bit_tick,   // line bit period pin
  input  wire logic                      line_pulse,      // bipolar activity pin
  input  wire logic [PTR_W-1:0]          fifo_rd_ptr,     // same clock
  input  wire logic [PTR_W-1:0]          fifo_wr_ptr,     // same clock
  input  wire logic                      loop_code_det,   // receive detector pin
  output logic                           irq_n,           // interrupt, low active
  output logic                           driver_monitor_alarm  // alarm status
);
  import line_unit_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] tick_s, pulse_s, nlc_s;  // two-stage synchronisers
  // first stage feeds only the second; all logic reads stage two
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tick_s  <= 2'h0;
      pulse_s <= 2'h0;
      nlc_s   <= 2'h0;
    end else begin
      tick_s  <= {tick_s[0], line_bit_tick};
      pulse_s <= {pulse_s[0], line_pulse};
      nlc_s   <= {nlc_s[0], loop_code_det};
    end
  end

  // delayed tick level; a rising edge of the synchronised pin is one bit period
  logic tick_q;  // previous tick level
  always_ff @(posedge mclk) begin
    if (!rstn) tick_q <= 1'b0;
    else       tick_q <= tick_s[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // driver monitor detector
  // quiet counter stepped by tick edges, cleared by line activity
  logic dmo_w;  // raw alarm
  dmo_detect #(.QUIET_BITS(`LU_DMO_BITS)) u_dmo (
    .mclk       (mclk),
    .rstn       (rstn),
    .bit_tick   (tick_s[1] & ~tick_q),
    .pulse_seen (pulse_s[1]),
    .alarm      (dmo_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // enable register
  localparam logic [7:0] EN_RESET = `LU_EN_RESET;  // whole-byte reset image
  logic en_dmo_r, en_fls_r, en_nlc_r;  // enable bits
  wire  wr_en  = host_wr && host_addr == `LU_IRQ_EN_ADDR;    // enable byte write
  wire  wr_clr = host_wr && host_addr == `LU_IRQ_STAT_ADDR;  // pending write-one clear
  // enables load from byte bits 6, 5 and 3; bits 7, 4 and 2 to 0 keep no storage
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      en_dmo_r <= EN_RESET[`LU_DMO_EN_BIT];
      en_fls_r <= EN_RESET[`LU_FLS_EN_BIT];
      en_nlc_r <= EN_RESET[`LU_NLC_EN_BIT];
    end else if (wr_en) begin
      en_dmo_r <= host_wdata[`LU_DMO_EN_BIT];
      en_fls_r <= host_wdata[`LU_FLS_EN_BIT];
      en_nlc_r <= host_wdata[`LU_NLC_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event detection
  logic dmo_q, nlc_q;  // previous levels
  // last levels for change detection; reset low like the idle sources
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dmo_q <= 1'b0;
      nlc_q <= 1'b0;
    end else begin
      dmo_q <= dmo_w;
      nlc_q <= nlc_s[1];
    end
  end

  // pointer distance, modular, either direction
  // d and its negation cover the write pointer behind or ahead
  function automatic logic near_ptr(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b);
    logic [PTR_W-1:0] d;
    d = a - b;
    near_ptr = (d <= PTR_W'(`LU_FIFO_NEAR)) || ((PTR_W'(0) - d) <= PTR_W'(`LU_FIFO_NEAR));
  endfunction : near_ptr

  logic fls_q;  // previous near level
  wire  fls_now = near_ptr(fifo_rd_ptr, fifo_wr_ptr);
  // near level follows same-clock pointers, no synchroniser needed
  always_ff @(posedge mclk) begin
    if (!rstn) fls_q <= 1'b0;
    else       fls_q <= fls_now;
  end

  // one-cycle event strobes: both alarm edges, near entry, both loop edges
  wire ev_dmo = dmo_w ^ dmo_q;
  wire ev_fls = fls_now & ~fls_q;
  wire ev_nlc = nlc_s[1] ^ nlc_q;

  ////////////////////////////////////////////////////////////////////////
  // pending bits, set wins over clear
  logic pend_dmo_r, pend_fls_r, pend_nlc_r;  // pending events
  // set needs the enable; an event in the clear cycle still lands
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pend_dmo_r <= 1'b0;
      pend_fls_r <= 1'b0;
      pend_nlc_r <= 1'b0;
    end else begin
      pend_dmo_r <= (en_dmo_r & ev_dmo) | (pend_dmo_r & ~(wr_clr & host_wdata[`LU_DMO_EN_BIT]));
      pend_fls_r <= (en_fls_r & ev_fls) | (pend_fls_r & ~(wr_clr & host_wdata[`LU_FLS_EN_BIT]));
      pend_nlc_r <= (en_nlc_r & ev_nlc) | (pend_nlc_r & ~(wr_clr & host_wdata[`LU_NLC_EN_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs and read back
  // registered interrupt and alarm pins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_n                <= 1'b1;
      driver_monitor_alarm <= 1'b0;
    end else begin
      irq_n                <= ~(pend_dmo_r | pend_fls_r | pend_nlc_r);
      driver_monitor_alarm <= dmo_w;
    end
  end

  // read data registered on the strobe, held until the next read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      host_rdata <= 8'h00;
    end else if (host_rd) begin
      unique case (host_addr)
        `LU_IRQ_EN_ADDR:   host_rdata <= {1'b0, en_dmo_r, en_fls_r, 1'b0, en_nlc_r, 3'h0};
        `LU_STATUS_ADDR:   host_rdata <= {1'b0, dmo_w, fls_now, 1'b0, nlc_s[1], 3'h0};
        `LU_IRQ_STAT_ADDR: host_rdata <= {1'b0, pend_dmo_r, pend_fls_r, 1'b0, pend_nlc_r, 3'h0};
        default:           host_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // enabled alarm change
  sequence s_dmo_edge;
    en_dmo_r && ev_dmo;
  endsequence
  // enabled loop code change
  sequence s_nlc_edge;
    en_nlc_r && ev_nlc;
  endsequence
  // any pending event
  sequence s_any_pend;
    pend_dmo_r || pend_fls_r || pend_nlc_r;
  endsequence
  // alarm change recorded one cycle on
  a_dmo_pend: assert property (@(posedge mclk) disable iff (!rstn)
    s_dmo_edge |=> pend_dmo_r)
    else $error("driver monitor edge lost");
  // near entry recorded one cycle on
  a_fls_pend: assert property (@(posedge mclk) disable iff (!rstn)
    en_fls_r && ev_fls |=> pend_fls_r)
    else $error("fifo limit event lost");
  // loop code change recorded one cycle on
  a_nlc_pend: assert property (@(posedge mclk) disable iff (!rstn)
    s_nlc_edge |=> pend_nlc_r)
    else $error("loop code event lost");
  // pin low the cycle after any pending bit
  a_irq_out: assert property (@(posedge mclk) disable iff (!rstn)
    s_any_pend |=> !irq_n)
    else $error("irq not raised");
  // pin released once nothing is pending
  a_irq_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !(pend_dmo_r || pend_fls_r || pend_nlc_r) |=> irq_n)
    else $error("irq without pending event");
  // loop code pending held until a write-one clear
  a_pend_hold: assert property (@(posedge mclk) disable iff (!rstn)
    pend_nlc_r && !wr_clr |=> pend_nlc_r)
    else $error("pending dropped");
  // write-one clear drops a pending bit with no new event
  a_pend_clr: assert property (@(posedge mclk) disable iff (!rstn)
    wr_clr && host_wdata[`LU_FLS_EN_BIT] && !ev_fls |=> !pend_fls_r)
    else $error("pending not cleared");
  // enable byte write lands in the alarm and loop bits
  a_en_write: assert property (@(posedge mclk) disable iff (!rstn)
    wr_en |=> en_dmo_r == $past(host_wdata[6]) && en_nlc_r == $past(host_wdata[3]))
    else $error("enable write lost");
  // enable byte write lands in the fifo bit
  a_en_fls: assert property (@(posedge mclk) disable iff (!rstn)
    wr_en |=> en_fls_r == $past(host_wdata[5]))
    else $error("fifo enable write lost");
  // reserved enable bits 7 and 4 read zero
  a_rsv_zero: assert property (@(posedge mclk) disable iff (!rstn)
    host_rd && host_addr == `LU_IRQ_EN_ADDR |=> host_rdata[7] == 1'b0 && host_rdata[4] == 1'b0)
    else $error("reserved bit nonzero");
  // disabled loop code change is not recorded
  a_no_dis: assert property (@(posedge mclk) disable iff (!rstn)
    !en_nlc_r && !pend_nlc_r |=> !pend_nlc_r)
    else $error("disabled event pended");
  // alarm pin follows the detector one cycle later
  a_alarm_out: assert property (@(posedge mclk) disable iff (!rstn)
    dmo_w |=> driver_monitor_alarm)
    else $error("alarm pin lagging");
endmodule : line_unit_irq
`default_nettype wire

// *** line_unit_defines.svh ***
// Purpose: constants for the line unit interrupt enable block
// Assumes: 8-bit host microprocessor port, byte registers
// Notes:   offsets are host port byte addresses
`ifndef LINE_UNIT_DEFINES_SVH
`define LINE_UNIT_DEFINES_SVH
`define LU_IRQ_EN_ADDR      16'h0f04
`define LU_STATUS_ADDR      16'h0f05
`define LU_IRQ_STAT_ADDR    16'h0f06
`define LU_DMO_EN_BIT       6
`define LU_FLS_EN_BIT       5
`define LU_NLC_EN_BIT       3
`define LU_EN_RESET         8'h00
`define LU_DMO_BITS         128
`define LU_FIFO_NEAR        3
`endif

// *** line_unit_pkg.sv ***
// Purpose: types for the line unit interrupt enable block
// Assumes: nothing beyond the defines header
// Notes:   types only
package line_unit_pkg;
  typedef logic [7:0] byte_t;  // host data byte
  typedef enum logic [1:0] {
    SRC_DMO,
    SRC_FLS,
    SRC_NLC
  } irq_src_t;                 // event sources
endpackage : line_unit_pkg

// *** dmo_detect.sv ***
// Purpose: driver monitor alarm from bipolar pulse activity
// Assumes: pulse_seen is a same-clock level, bit_tick a same-clock strobe
// Notes:   alarm drops in the cycle activity returns
`include "line_unit_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dmo_detect #(
  parameter int QUIET_BITS = `LU_DMO_BITS  // bit periods without pulses
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic bit_tick,    // one pulse per line bit period
  input  wire logic pulse_seen,  // bipolar pulse on line output
  output logic      alarm        // driver monitor alarm
);
  logic [$clog2(QUIET_BITS+1)-1:0] quiet_r;  // quiet bit counter

  // count quiet bit periods, clear on any pulse
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      quiet_r <= '0;
    end else if (pulse_seen) begin
      quiet_r <= '0;
    end else if (bit_tick && quiet_r != QUIET_BITS[$bits(quiet_r)-1:0]) begin
      quiet_r <= quiet_r + 1'b1;
    end
  end

  // alarm at count reached, cleared the instant pulses return
  assign alarm = !pulse_seen && (quiet_r == QUIET_BITS[$bits(quiet_r)-1:0]);

  // activity drops the alarm in the same cycle
  a_dmo_clear: assert property (@(posedge mclk) disable iff (!rstn)
    pulse_seen |-> !alarm)
    else $error("alarm while pulses present");
  // activity restarts the quiet count
  a_dmo_restart: assert property (@(posedge mclk) disable iff (!rstn)
    pulse_seen |=> quiet_r == '0)
    else $error("quiet count not restarted");
endmodule : dmo_detect
`default_nettype wire

// *** line_unit_irq_bench.sv ***
// Purpose: self-checking bench for the line unit interrupt enable block
// Assumes: host strobes one cycle wide, read data valid the cycle after
// Notes:   pins are driven slowly enough for the synchronisers
`timescale 1ns/1ps
`default_nettype none
module line_unit_irq_bench;
  import line_unit_pkg::*;
  typedef struct {byte_t wdata; byte_t rexp;} row_t;  // enable write and readback
  logic        mclk = 0, rstn = 0, host_wr = 0, host_rd = 0;  // clock, reset, strobes
  logic [15:0] host_addr = 16'h0000;                          // host address
  byte_t       host_wdata = 8'h00, host_rdata, rd_v;          // host data
  logic        line_bit_tick = 0, line_pulse = 1, loop_code_det = 0;  // line pins
  logic [4:0]  fifo_rd_ptr = 5'h00, fifo_wr_ptr = 5'h10;      // far apart at start
  logic        irq_n, driver_monitor_alarm;                   // design outputs
  int          num_errors = 0, n_checks = 0;                  // counters
  row_t        rows [4] = '{'{8'hff, 8'h68}, '{8'h48, 8'h48}, '{8'h20, 8'h20}, '{8'h00, 8'h00}};
  line_unit_irq #(.PTR_W(5)) i_dut (.mclk(mclk), .rstn(rstn), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .line_bit_tick(line_bit_tick), .line_pulse(line_pulse), .fifo_rd_ptr(fifo_rd_ptr),
    .fifo_wr_ptr(fifo_wr_ptr), .loop_code_det(loop_code_det), .irq_n(irq_n),
    .driver_monitor_alarm(driver_monitor_alarm));
  // 25 MHz clock
  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input byte_t seen, input byte_t exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one write cycle
  task wr(input logic [15:0] a, input byte_t d);
    @(posedge mclk) {host_addr, host_wdata, host_wr} <= {a, d, 1'b1};
    @(posedge mclk) host_wr <= 1'b0;
  endtask : wr
  // one read cycle, data taken once settled
  task rd(input logic [15:0] a);
    @(posedge mclk) {host_addr, host_rd} <= {a, 1'b1};
    @(posedge mclk) host_rd <= 1'b0;
    @(posedge mclk) #1 rd_v = host_rdata;
  endtask : rd
  // bounded wait for irq_n to reach a level, then compare
  task irq_is(input logic lvl, input int n);
    #1;  // look only after the edge's updates have settled
    for (int i = 0; i < n && irq_n !== lvl; i++) @(posedge mclk) #1;
    chk({7'h00, irq_n}, {7'h00, lvl});
  endtask : irq_is
  // line bit periods, two cycles each
  task ticks(input int n);
    repeat (n) begin
      @(posedge mclk) line_bit_tick <= 1'b1;
      @(posedge mclk) line_bit_tick <= 1'b0;
    end
  endtask : ticks
  // counts and verdict
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  // main sequence; pins model a single-rail line, one activity pin
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    rd(16'h0f04); chk(rd_v, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    foreach (rows[i]) begin
      wr(16'h0f04, rows[i].wdata);
      rd(16'h0f04); chk(rd_v, rows[i].rexp);
    end
    rd(16'h0123); chk(rd_v, 8'h00);
    // disabled: a loop code edge leaves nothing pending; enabled: both edges pend
    @(posedge mclk) loop_code_det <= 1'b1;
    repeat (8) @(posedge mclk);
    wr(16'h0f04, 8'h08); repeat (6) @(posedge mclk); irq_is(1'b1, 1);
    @(posedge mclk) loop_code_det <= 1'b0;
    irq_is(1'b0, 10);
    rd(16'h0f06); chk(rd_v & 8'h08, 8'h08);
    repeat (4) @(posedge mclk); irq_is(1'b0, 1);
    wr(16'h0f06, 8'h08); irq_is(1'b1, 4);
    @(posedge mclk) loop_code_det <= 1'b1;
    irq_is(1'b0, 10);
    wr(16'h0f06, 8'h08); irq_is(1'b1, 4);
    // fifo pointers come within three
    wr(16'h0f04, 8'h20);
    @(posedge mclk) fifo_wr_ptr <= 5'h04;  // four apart, outside the limit
    repeat (6) @(posedge mclk); irq_is(1'b1, 1);
    @(posedge mclk) fifo_wr_ptr <= 5'h03;  // write three ahead
    irq_is(1'b0, 8);
    wr(16'h0f06, 8'h20); irq_is(1'b1, 4);
    // read three ahead of write, from far apart
    @(posedge mclk) fifo_wr_ptr <= 5'h10;
    @(posedge mclk) fifo_rd_ptr <= 5'h13;
    irq_is(1'b0, 8);
    wr(16'h0f06, 8'h20); irq_is(1'b1, 4);
    // driver monitor alarm after quiet bit periods
    wr(16'h0f04, 8'h40);
    @(posedge mclk) line_pulse <= 1'b0;
    // 127 quiet bits leave the alarm off, the 128th raises it
    ticks(127); repeat (3) @(posedge mclk); #1 chk({7'h00, driver_monitor_alarm}, 8'h00);
    ticks(1); repeat (4) @(posedge mclk); #1 chk({7'h00, driver_monitor_alarm}, 8'h01);
    irq_is(1'b0, 6);
    wr(16'h0f06, 8'h40); irq_is(1'b1, 4);
    @(posedge mclk) line_pulse <= 1'b1;
    repeat (6) @(posedge mclk); #1 chk({7'h00, driver_monitor_alarm}, 8'h00);
    irq_is(1'b0, 6);
    // reset in mid-run clears enables and output
    @(posedge mclk) rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    #1 chk({7'h00, irq_n}, 8'h01);
    rd(16'h0f04); chk(rd_v, 8'h00);
    final_report();
  end
endmodule : line_unit_irq_bench
`default_nettype wire
